// *** dv/dsl_ctl_model.sv ***
// Controller model that bit-bangs the link pins of the load logic.
// Assumes clk_sys paces it; pins change on its falling edge.
`timescale 1ns/1ps
module dsl_ctl_model
   import dsl_pkg::*;
(
   // Timing reference
   input wire logic clk_sys,
   // Link pins
   output logic serialDataIn,
   output logic serialClk,
   output logic loadStrobe_n,
   output logic clear_n
);
   // Idle pins: clock low, strobe and clear inactive
   initial begin
      serialDataIn = 1'b0;
      serialClk = 1'b0;
      loadStrobe_n = 1'b1;
      clear_n = 1'b1;
   end
   // Sixteen-bit frame, top bit first; clock stands still after it
   task automatic send(input logic [15:0] frame);
      @(negedge clk_sys);
      // Data moves with the falling link clock, so a period is two half periods
      for (int i = 15; i >= 0; i--) begin
         serialDataIn = frame[i];
         repeat (DSL_LINK_HALF_CYCLES) @(negedge clk_sys);
         serialClk = 1'b1;
         repeat (DSL_LINK_HALF_CYCLES) @(negedge clk_sys);
         serialClk = 1'b0;
      end
      // Data no longer held, so show a level that can't pass for the last bit
      serialDataIn = ~frame[0];
   endtask
   // Control pins together
   task automatic pins(input logic ld, input logic clr);
      @(negedge clk_sys);
      loadStrobe_n = ld;
      clear_n = clr;
   endtask
endmodule

// *** dv/dsl_serial_load_tb_top.sv ***
// Bench for both variants of the serial load logic on one link.
// Assumes the package, design and controller model are compiled first.
`timescale 1ns/1ps
module dsl_serial_load_tb_top;
   import dsl_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic serialDataIn, serialClk, loadStrobe_n, clear_n;
   logic [11:0] codeHigh;
   logic [9:0] codeLow;
   logic updHigh, updLow;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   // Both variants hang on the same pins
   dsl_serial_load #(.CODE_BITS(DSL_BITS_HIGH)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .serialDataIn(serialDataIn), .serialClk(serialClk), .loadStrobe_n(loadStrobe_n),
      .clear_n(clear_n), .converterCode(codeHigh), .codeUpdated(updHigh));
   dsl_serial_load #(.CODE_BITS(DSL_BITS_LOW)) u_dut_low (.clk_sys(clk_sys), .reset_n(reset_n),
      .serialDataIn(serialDataIn), .serialClk(serialClk), .loadStrobe_n(loadStrobe_n),
      .clear_n(clear_n), .converterCode(codeLow), .codeUpdated(updLow));
   dsl_ctl_model u_ctl (.clk_sys(clk_sys), .serialDataIn(serialDataIn), .serialClk(serialClk),
      .loadStrobe_n(loadStrobe_n), .clear_n(clear_n));
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Pin change, then code and one-cycle pulse three edges on
   task automatic load(input logic ld, input logic clr,
      input logic [11:0] eh, input logic [9:0] el);
      u_ctl.pins(ld, clr);
      repeat (3) @(posedge clk_sys);
      #1;
      check(codeHigh, eh, "code12");
      check({2'h0, codeLow}, {2'h0, el}, "code10");
      check({10'h0, updHigh, updLow}, 12'h003, "pulse");
      @(posedge clk_sys);
      #1;
      check({10'h0, updHigh, updLow}, 12'h000, "pulse end");
   endtask
   task automatic t_frame;
      u_ctl.send(16'ha5c3);
      check(codeHigh, 12'h000, "preload12");
      check({2'h0, codeLow}, 12'h000, "preload10");
      load(1'b0, 1'b1, 12'h5c3, 10'h1c3);
      u_ctl.pins(1'b1, 1'b1);
      u_ctl.send(16'h3ffe);
      check(codeHigh, 12'h5c3, "old code kept");
      load(1'b0, 1'b1, 12'hffe, 10'h3fe);
      $display("frame test done");
   endtask
   task automatic t_gate;
      u_ctl.send(16'h0000);
      u_ctl.pins(1'b1, 1'b1);
      repeat (4) @(negedge clk_sys);
      load(1'b0, 1'b1, 12'hffe, 10'h3fe);
      $display("gate test done");
   endtask
   task automatic t_clear;
      u_ctl.pins(1'b1, 1'b1);
      u_ctl.send(16'h0123);
      u_ctl.pins(1'b1, 1'b0);
      repeat (4) @(negedge clk_sys);
      check(codeHigh, 12'h000, "cleared");
      u_ctl.pins(1'b0, 1'b0);
      repeat (5) @(negedge clk_sys);
      check(codeHigh, 12'h000, "held12");
      check({2'h0, codeLow}, 12'h000, "held10");
      load(1'b0, 1'b1, 12'h123, 10'h123);
      // Recommended order: strobe up first, then clear released, no transfer
      u_ctl.pins(1'b1, 1'b0);
      repeat (4) @(negedge clk_sys);
      u_ctl.pins(1'b1, 1'b1);
      repeat (5) @(negedge clk_sys);
      check(codeHigh, 12'h000, "quiet12");
      check({2'h0, codeLow}, 12'h000, "quiet10");
      load(1'b0, 1'b1, 12'h123, 10'h123);
      $display("clear test done");
   endtask
   task automatic t_reset;
      u_ctl.pins(1'b1, 1'b1);
      @(negedge clk_sys);
      reset_n = 1'b0;
      @(negedge clk_sys);
      check(codeHigh, 12'h000, "reset12");
      check({2'h0, codeLow}, 12'h000, "reset10");
      check({10'h0, updHigh, updLow}, 12'h000, "reset pulse");
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      check(codeHigh, 12'h000, "after reset");
      u_ctl.send(16'hf9a6);
      load(1'b0, 1'b1, 12'h9a6, 10'h1a6);
      $display("reset test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Hang guard; the tests need about 720 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         $display("ERROR %0t timeout", $time);
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_frame();
      t_gate();
      t_clear();
      t_reset();
      wrap_up();
   end
endmodule

// *** shared/dsl_pkg.sv ***
// Constants for the serial load logic of the converter front end.
// Assumes a single system clock domain; the link pins are sampled in it.
package dsl_pkg;
   // Resolution of the two variants
   localparam int DSL_BITS_HIGH = 12;
   localparam int DSL_BITS_LOW = 10;
   // Synchroniser depth for pin inputs
   localparam int DSL_SYNC_STAGES = 2;
   // Reset values
   localparam logic [DSL_BITS_HIGH-1:0] DSL_CODE_RESET = 12'h000;
   localparam logic [DSL_SYNC_STAGES-1:0] DSL_SYNC_HIGH = 2'h3;
   localparam logic [DSL_SYNC_STAGES-1:0] DSL_SYNC_LOW = 2'h0;
   // Link clock period in the bench, in ns, and system clock period in ns
   localparam int DSL_LINK_PERIOD_NS = 400;
   localparam int DSL_SYS_PERIOD_NS = 50;
   // Whole system cycles in one link clock half period (rounded down)
   localparam int DSL_LINK_HALF_CYCLES = (DSL_LINK_PERIOD_NS / 2) / DSL_SYS_PERIOD_NS;
endpackage

// *** src/dsl_pin_sync.sv ***
// Two flip-flop synchroniser with rising and falling edge detection.
// Assumes an asynchronous pin input; the first stage feeds only the second.
`timescale 1ns/1ps
module dsl_pin_sync
   import dsl_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Pin side
   input wire logic pinIn,
   // Synchronised level and edges
   output logic levelOut,
   output logic riseOut,
   output logic fallOut
);
   logic [DSL_SYNC_STAGES-1:0] sync_reg;
   logic last_reg;

   // Stage 0 feeds stage 1 only; edges use stage 1 and its delayed copy
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync_reg <= RESET_LEVEL ? DSL_SYNC_HIGH : DSL_SYNC_LOW;
         last_reg <= RESET_LEVEL;
      end else begin
         sync_reg <= {sync_reg[0], pinIn};
         last_reg <= sync_reg[1];
      end
   end

   // Edge detection on the settled stage
   assign levelOut = sync_reg[1];
   assign riseOut = sync_reg[1] & ~last_reg;
   assign fallOut = ~sync_reg[1] & last_reg;
endmodule

// *** src/dsl_serial_load.sv ***
// Serial load logic: shift register, converter register, load and clear.
// Assumes link pins come straight from a controller, asynchronous to clk_sys.
`timescale 1ns/1ps
module dsl_serial_load
   import dsl_pkg::*;
#(
   parameter int CODE_BITS = DSL_BITS_HIGH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Serial link pins
   input wire logic serialDataIn,
   input wire logic serialClk,
   input wire logic loadStrobe_n,
   input wire logic clear_n,
   // Converter side
   output logic [CODE_BITS-1:0] converterCode,
   output logic codeUpdated
);
   // Clear tracker: CLEARED from reset until the synchronised clear is seen high
   typedef enum logic [1:0] {DSL_IDLE, DSL_CLEARED} dsl_state_t;

   // Shift register and its next value
   logic [CODE_BITS-1:0] shift_reg;
   logic [CODE_BITS-1:0] shift_next;
   // Converter register, its next value and the update pulse
   logic [CODE_BITS-1:0] code_reg;
   logic [CODE_BITS-1:0] code_next;
   logic upd_reg;
   // Clear tracker state
   dsl_state_t state_reg;
   dsl_state_t state_next;
   // Synchronised levels and edges of the pins
   logic dataLvl;
   logic clkRise;
   logic ldLvl;
   logic ldFall;
   logic clrLvl;
   logic clrRise;
   // Decoded strobes
   logic shiftEn;
   logic clrRelease;
   logic transferEn;

   // One bit in at the bottom; the oldest bit drops off the top
   function automatic logic [CODE_BITS-1:0] shiftInBit(
      input logic [CODE_BITS-1:0] cur,
      input logic bitIn
   );
      return {cur[CODE_BITS-2:0], bitIn};
   endfunction

   // Serial data takes the same two stages as the link clock,
   // so setup and hold at the pin carry over to the sampled copy
   dsl_pin_sync #(
      .RESET_LEVEL(1'b0)
   ) uDataSync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pinIn(serialDataIn),
      .levelOut(dataLvl),
      .riseOut(),
      .fallOut()
   );

   // Link clock idles low; only its rising edge is used
   dsl_pin_sync #(
      .RESET_LEVEL(1'b0)
   ) uClkSync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pinIn(serialClk),
      .levelOut(),
      .riseOut(clkRise),
      .fallOut()
   );

   // Load strobe idles high, so its stages reset high to avoid a false fall
   dsl_pin_sync #(
      .RESET_LEVEL(1'b1)
   ) uLdSync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pinIn(loadStrobe_n),
      .levelOut(ldLvl),
      .riseOut(),
      .fallOut(ldFall)
   );

   // Clear stages reset low: the code stays zero until clear is seen high,
   // and a strobe held low through reset then loads the shift register
   dsl_pin_sync #(
      .RESET_LEVEL(1'b0)
   ) uClrSync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pinIn(clear_n),
      .levelOut(clrLvl),
      .riseOut(clrRise),
      .fallOut()
   );

   // Link clock edges count only while the strobe is high; each link
   // level must last over one clk_sys cycle or an edge is missed
   assign shiftEn = clkRise & ldLvl;
   // Oldest bits fall off the top, so a long frame keeps the last CODE_BITS
   assign shift_next = shiftEn ? shiftInBit(shift_reg, dataLvl) : shift_reg;
   // First cycle with clear high after the tracker saw it low
   assign clrRelease = (state_reg == DSL_CLEARED) & clrLvl;
   // Transfer on strobe fall, or on clear release with the strobe still low;
   // it lands three clk_sys edges after the pin edge (two stages, one register)
   assign transferEn = clrLvl & (ldFall | (clrRelease & ~ldLvl));
   // Clear wins over a transfer in the same cycle; otherwise the code holds
   assign code_next = !clrLvl ? DSL_CODE_RESET[CODE_BITS-1:0] :
      (transferEn ? shift_reg : code_reg);

   // Clear tracker next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DSL_IDLE: begin
            if (!clrLvl) begin
               state_next = DSL_CLEARED;
            end
         end
         DSL_CLEARED: begin
            if (clrLvl) begin
               state_next = DSL_IDLE;
            end
         end
         default: begin
            state_next = DSL_IDLE;
         end
      endcase
   end

   // Register update; the reset branch loads constants only
   // Tracker starts in CLEARED so a clear released after reset is caught
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shift_reg <= DSL_CODE_RESET[CODE_BITS-1:0];
         code_reg <= DSL_CODE_RESET[CODE_BITS-1:0];
         upd_reg <= 1'b0;
         state_reg <= DSL_CLEARED;
      end else begin
         shift_reg <= shift_next;
         code_reg <= code_next;
         upd_reg <= transferEn;
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign converterCode = code_reg;
   assign codeUpdated = upd_reg;

   // Shift path checks
   // Gating and order are checked against the synchronised pins
   chk_shift_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !ldLvl |=> $stable(shift_reg))
      else $error("shift while strobe low");
   chk_shift_msb: assert property (@(posedge clk_sys) disable iff (!reset_n)
      shiftEn |=> shift_reg == shiftInBit($past(shift_reg), $past(dataLvl)))
      else $error("shift order wrong");
   chk_keep_last: assert property (@(posedge clk_sys) disable iff (!reset_n)
      shiftEn |=> shift_reg[0] == $past(dataLvl))
      else $error("last bit lost");

   // Converter register checks
   chk_code_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (clrLvl && !transferEn) |=> $stable(code_reg))
      else $error("code moved");
   chk_load_copy: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (ldFall && clrLvl) |=> code_reg == $past(shift_reg))
      else $error("no load");
   chk_upd_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      1'b1 |=> upd_reg == $past(transferEn))
      else $error("update pulse wrong");
   chk_clear_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !clrLvl |=> code_reg == '0)
      else $error("clear failed");
   chk_clear_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (!clrLvl && ldFall) |=> !upd_reg)
      else $error("load during clear");
   chk_state_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !clrLvl |=> state_reg == DSL_CLEARED)
      else $error("tracker missed clear");

   // Clear release checks; a release with the strobe high must stay quiet
   chk_release_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (clrRise && !ldLvl) |=> code_reg == $past(shift_reg) && upd_reg)
      else $error("no load at clear release");
   chk_release_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (clrRelease && ldLvl) |=> !upd_reg)
      else $error("load at quiet release");
   chk_release_track: assert property (@(posedge clk_sys) disable iff (!reset_n)
      clrRelease == clrRise)
      else $error("release tracker out of step");

   // Main scenarios: loads, releases, gated strobes and back-to-back bits
   // One link period is eight clk_sys cycles in the bench
   cov_load: cover property (@(posedge clk_sys) ldFall && clrLvl);
   cov_clear: cover property (@(posedge clk_sys) clrRise && !ldLvl);
   cov_shift: cover property (@(posedge clk_sys) shiftEn ##8 shiftEn);
   cov_clear_hold: cover property (@(posedge clk_sys) !clrLvl && ldFall);
   cov_quiet_release: cover property (@(posedge clk_sys) clrRelease && ldLvl);
endmodule
